/* shared/ffps_pkg.sv */
// Constants, types and helpers for the feedforward pre-boost sequencer.
package ffps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;     // Unit clock rate in MHz.
  localparam int TICK_TIME_US   = 25000;  // Base tick, a quarter of 0.1 s.
  localparam int TICK_CYCLES    = CLK_MHZ * TICK_TIME_US;
  localparam int TICKS_PER_WAIT = 4;      // Base ticks in one 0.1 s unit.
  localparam int TICKS_PER_QSEC = 10;     // Base ticks in a quarter of 1 s.

  // ----------------------------------------------------------------
  // Field widths and values after reset
  // ----------------------------------------------------------------
  localparam int WAIT_W    = 11;  // Waiting time, 0 to 2000.
  localparam int OPT_W     = 12;  // Operation time, 1 to 3600 s.
  localparam int SEG_W     = 12;  // Segment value, -1999 to 1999.
  localparam int COEF_W    = 10;  // Coefficient, 1 to 999.
  localparam int CONTRIB_W = 16;  // Scaled segment value.
  localparam int LOOP_W    = 16;  // Loop output from the PID stage.
  localparam int MV_W      = 18;  // Summed manipulated output.
  localparam int CNT_W     = 16;  // Tick down-counter.
  localparam logic [WAIT_W-1:0] WAIT_RST = 11'h000;
  localparam logic [OPT_W-1:0]  OPT_RST  = 12'h001;
  localparam logic [SEG_W-1:0]  SEG_RST  = 12'h000;
  localparam logic [COEF_W-1:0] COEF_RST = 10'h064;  // Unity gain, 100.
  localparam int                COEF_UNITY = 100;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS2_OFS = 8'h04;
  localparam logic [7:0] INST_BASE   = 8'h10;
  localparam int         INST_BIT    = 5;     // Bit of the offset from INST_BASE picking the instance.
  localparam logic [2:0] F_WAIT      = 3'h0;  // Word slots inside an instance.
  localparam logic [2:0] F_OPT       = 3'h1;
  localparam logic [2:0] F_SEG1      = 3'h2;
  localparam logic [2:0] F_COEF      = 3'h6;
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_EXEC1_BIT  = 1;
  localparam int CTRL_EXEC2_BIT  = 2;
  localparam int CTRL_CANCEL_BIT = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEG  = 2'b10
  } ffps_state_type;

  // Scales a segment value by a coefficient in 0.01 units, toward zero.
  function automatic logic signed [CONTRIB_W-1:0] scale_seg(
      input logic signed [SEG_W-1:0] seg,
      input logic        [COEF_W-1:0] coef);
    logic signed [SEG_W+COEF_W:0] prod;
    prod = seg * $signed({1'b0, coef});
    return CONTRIB_W'(prod / COEF_UNITY);
  endfunction

endpackage

/* core/ffps_tick.sv */
// Free-running base tick generator for the sequencer timing.
module ffps_tick
  import ffps_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // One-cycle tick pulse.
  output logic      tick
);

  logic [31:0] cnt_r;  // Cycles since the last tick.

  // ----------------------------------------------------------------
  // Counter and pulse
  // ----------------------------------------------------------------
  // The counter never stops, so a first interval may be up to one tick short.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == 32'(CYCLES - 1));
      cnt_r <= (cnt_r == 32'(CYCLES - 1)) ? 32'h0 : cnt_r + 32'h1;
    end
  end

endmodule

/* core/ffps_seq.sv */
// One pre-boost instance: waiting interval followed by four segments.
module ffps_seq
  import ffps_pkg::*;
(
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  // Timing and control.
  input  wire logic                        tick,
  input  wire logic                        start,
  input  wire logic                        abort,
  // Settings.
  input  wire logic [WAIT_W-1:0]           wait_val,
  input  wire logic [OPT_W-1:0]            opt_val,
  input  wire logic [3:0][SEG_W-1:0]       seg_vals,
  input  wire logic [COEF_W-1:0]           coef,
  // State and contribution.
  output logic                             run,
  output logic                             in_seg,
  output logic [1:0]                       seg_idx,
  output logic signed [CONTRIB_W-1:0]      contrib
);

  ffps_state_type   state_r, state_nxt;  // Sequencer state.
  logic [CNT_W-1:0] cnt_r, cnt_nxt;      // Ticks left in this interval.
  logic [1:0]       idx_r, idx_nxt;      // Active segment.
  logic [CNT_W-1:0] wait_load;           // Waiting interval in ticks.
  logic [CNT_W-1:0] qtr_load;            // One quarter in ticks.
  logic             last_tick;           // Interval ends on this tick.

  assign wait_load = CNT_W'(wait_val) * CNT_W'(TICKS_PER_WAIT);
  assign qtr_load  = CNT_W'(opt_val) * CNT_W'(TICKS_PER_QSEC);
  // A zero count ends at the next tick rather than wrapping round.
  assign last_tick = tick && (cnt_r <= CNT_W'(1));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    if (abort) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            idx_nxt   = 2'h0;
            state_nxt = (wait_load == '0) ? ST_SEG : ST_WAIT;
            cnt_nxt   = (wait_load == '0) ? qtr_load : wait_load;
          end
        end
        ST_WAIT: begin
          if (last_tick) begin
            state_nxt = ST_SEG;
            cnt_nxt   = qtr_load;
          end else if (tick) begin
            cnt_nxt = cnt_r - CNT_W'(1);
          end
        end
        ST_SEG: begin
          if (last_tick) begin
            // Each segment lasts one quarter, in order one to four.
            if (idx_r == 2'h3) begin
              state_nxt = ST_IDLE;
            end else begin
              idx_nxt = idx_r + 2'h1;
              cnt_nxt = qtr_load;
            end
          end else if (tick) begin
            cnt_nxt = cnt_r - CNT_W'(1);
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      idx_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
    end
  end

  // Outputs; the contribution is zero outside the segments.
  assign run     = (state_r != ST_IDLE);
  assign in_seg  = (state_r == ST_SEG);
  assign seg_idx = idx_r;
  assign contrib = in_seg ? scale_seg(seg_vals[idx_r], coef) : '0;

endmodule

/* core/ffps_sequencer.sv */
// Top of the feedforward pre-boost sequencer with its AHB-Lite registers.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module ffps_sequencer
  import ffps_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // AHB-Lite slave.
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // Commands that abort a running sequence.
  input  wire logic                     manual_cmd,
  input  wire logic                     stop_cmd,
  input  wire logic                     tune_start,
  input  wire logic                     invert_cmd,
  input  wire logic                     input_error,
  // Results of the disturbance autotune procedure.
  input  wire logic                     at_done,
  input  wire logic                     at_sel,
  input  wire logic [WAIT_W-1:0]        at_wait,
  input  wire logic [OPT_W-1:0]         at_opt,
  input  wire logic [4*SEG_W-1:0]       at_segs,
  // Loop output in and summed output out.
  input  wire logic signed [LOOP_W-1:0] loop_output,
  output logic signed [MV_W-1:0]        manipulated_output
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Bus pipeline.
  logic        ap_valid;     // Address phase taken this edge.
  logic [7:0]  addr_r;       // Latched byte address.
  logic        map_r;        // Latched address lies in the low page.
  logic        wr_pend_r;    // Write data phase in progress.
  logic        rd_pend_r;    // Read data phase, one wait state.
  logic        hreadyout_r;  // Ready towards the master.
  logic [31:0] hrdata_r;     // Read data register.
  logic [31:0] rd_data;      // Read mux result.

  // Write decode.
  logic        wr_en;        // A mapped write completes this edge.
  logic        wr_ctrl;      // Write to the control word.
  logic        wr_inst;      // Write inside an instance block.
  logic        wr_sel;       // Which instance a write targets.
  logic [2:0]  wr_slot;      // Which word inside the instance.

  // Settings: one shared mode bit, then one set per instance.
  logic              preboost_run_mode_r;  // 0 feedforward, 1 autotune.
  logic [WAIT_W-1:0] wait_r [2];
  logic [OPT_W-1:0]  opt_r  [2];
  logic [3:0][SEG_W-1:0] seg_r [2];
  logic [COEF_W-1:0] coef_r [2];

  // Commands and per-instance state.
  logic exec_one;    // Software asks instance one to execute.
  logic exec_two;    // Software asks instance two to execute.
  logic cancel;      // Software cancel.
  logic abort;       // Any abort cause.
  logic tick;        // Base tick.
  logic start [2];   // Accepted start per instance.
  logic run [2];
  logic in_seg [2];
  logic [1:0] seg_idx [2];
  logic signed [CONTRIB_W-1:0] contrib [2];
  logic signed [MV_W-1:0]      mv_nxt;
  logic signed [MV_W-1:0]      mv_r;

  // ----------------------------------------------------------------
  // Register slot decode
  // ----------------------------------------------------------------
  // Slot of an instance word, or 3'h7 when outside the blocks.
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - INST_BASE;
    if (a < INST_BASE || off[7:INST_BIT+1] != '0 || off[4:2] == 3'h7) begin
      return 3'h7;
    end
    return off[4:2];
  endfunction

  // Instance selected by an address inside the blocks.
  function automatic logic inst_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - INST_BASE;
    return off[INST_BIT];
  endfunction

  // Read value of one instance word; segments sign-extend. The settings come in as
  // arguments so that the read mux follows every change of them, not only of the address.
  function automatic logic [31:0] inst_word(input logic [WAIT_W-1:0] w, input logic [OPT_W-1:0] o,
      input logic [COEF_W-1:0] c, input logic [3:0][SEG_W-1:0] sv, input logic [2:0] f);
    logic [31:0] v;
    v = 32'h0;
    if (f == F_WAIT) begin
      v = 32'(w);
    end else if (f == F_OPT) begin
      v = 32'(o);
    end else if (f == F_COEF) begin
      v = 32'(c);
    end else if (f != 3'h7) begin
      v = 32'($signed(sv[f - F_SEG1]));
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave pipeline
  // ----------------------------------------------------------------
  assign ap_valid = hsel && htrans[1] && hready;

  // Writes finish with no wait state; reads take one so that a read
  // right after a write always sees the value just stored.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r      <= 8'h00;
      map_r       <= 1'b0;
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      hreadyout_r <= 1'b1;
    end else if (ap_valid) begin
      addr_r      <= haddr[7:0];
      map_r       <= (haddr[31:8] == 24'h0);
      wr_pend_r   <= hwrite;
      rd_pend_r   <= !hwrite;
      hreadyout_r <= hwrite;
    end else begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      hreadyout_r <= 1'b1;
    end
  end

  // Read data is captured in the wait state.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_r <= 32'h0;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_data;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = 1'b0;  // Always OKAY; unmapped reads give zero.

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // The status word shows mode in bit 0 and the two runs above it.
  assign rd_data = !map_r ? 32'h0 :
                   (addr_r == CTRL_OFS) ? {31'h0, preboost_run_mode_r} :
                   (addr_r == STATUS2_OFS) ? {29'h0, run[1], run[0], preboost_run_mode_r} :
                   inst_word(wait_r[wr_sel], opt_r[wr_sel], coef_r[wr_sel], seg_r[wr_sel], wr_slot);

  // ----------------------------------------------------------------
  // Write decode and commands
  // ----------------------------------------------------------------
  assign wr_en    = wr_pend_r && map_r;
  assign wr_ctrl  = wr_en && (addr_r == CTRL_OFS);
  assign wr_slot  = slot_of(addr_r);
  assign wr_sel   = inst_of(addr_r);
  assign wr_inst  = wr_en && (wr_slot != 3'h7);
  assign exec_one = wr_ctrl && hwdata[CTRL_EXEC1_BIT];
  assign exec_two = wr_ctrl && hwdata[CTRL_EXEC2_BIT];
  assign cancel   = wr_ctrl && hwdata[CTRL_CANCEL_BIT];

  // Every documented cause ends both instances at once.
  assign abort = cancel || manual_cmd || stop_cmd || tune_start ||
                 invert_cmd || input_error;

  // A start is taken only in feedforward mode and only while neither
  // instance runs; if both are asked together, instance one wins.
  assign start[0] = exec_one && !preboost_run_mode_r && !run[0] && !run[1] && !abort;
  assign start[1] = exec_two && !exec_one && !preboost_run_mode_r &&
                    !run[0] && !run[1] && !abort;

  // Mode bit of the control word.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      preboost_run_mode_r <= 1'b0;
    end else if (wr_ctrl) begin
      preboost_run_mode_r <= hwdata[CTRL_MODE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Instance settings and sequencers
  // ----------------------------------------------------------------
  ffps_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  for (genvar g = 0; g < 2; g++) begin : g_inst
    logic at_hit;  // Autotune results aimed at this instance.
    logic sw_hit;  // Software write aimed at this instance.

    assign at_hit = at_done && (at_sel == 1'(g));
    assign sw_hit = wr_inst && (wr_sel == 1'(g));

    // Autotune results take priority over a software write in the same
    // cycle; the coefficient stays the host's to set.
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        wait_r[g] <= WAIT_RST;
        opt_r[g]  <= OPT_RST;
        seg_r[g]  <= {4{SEG_RST}};
        coef_r[g] <= COEF_RST;
      end else if (at_hit) begin
        wait_r[g] <= at_wait;
        opt_r[g]  <= at_opt;
        seg_r[g]  <= at_segs;
      end else if (sw_hit) begin
        if (wr_slot == F_WAIT) begin
          wait_r[g] <= hwdata[WAIT_W-1:0];
        end else if (wr_slot == F_OPT) begin
          opt_r[g] <= hwdata[OPT_W-1:0];
        end else if (wr_slot == F_COEF) begin
          coef_r[g] <= hwdata[COEF_W-1:0];
        end else begin
          seg_r[g][wr_slot - F_SEG1] <= hwdata[SEG_W-1:0];
        end
      end
    end

    ffps_seq u_seq (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .tick     (tick),
      .start    (start[g]),
      .abort    (abort),
      .wait_val (wait_r[g]),
      .opt_val  (opt_r[g]),
      .seg_vals (seg_r[g]),
      .coef     (coef_r[g]),
      .run      (run[g]),
      .in_seg   (in_seg[g]),
      .seg_idx  (seg_idx[g]),
      .contrib  (contrib[g])
    );
  end

  // ----------------------------------------------------------------
  // Output summation
  // ----------------------------------------------------------------
  // Only one instance can run, so the sum cannot exceed the output width.
  assign mv_nxt = MV_W'(loop_output) + MV_W'(contrib[0]) + MV_W'(contrib[1]);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mv_r <= '0;
    end else begin
      mv_r <= mv_nxt;
    end
  end

  assign manipulated_output = mv_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_wait_holdoff: assert property (
    start[0] && wait_r[0] != '0 |=> run[0] && !in_seg[0])
    else $error("Segment began before the waiting time.");

  chk_quarter_step: assert property (
    in_seg[0] && $past(in_seg[0]) && $changed(seg_idx[0]) |-> $past(tick))
    else $error("Segment changed without a tick.");

  chk_seg_order: assert property (
    in_seg[0] && $past(in_seg[0]) && $changed(seg_idx[0]) |->
      seg_idx[0] == $past(seg_idx[0]) + 2'h1)
    else $error("Segments left their order.");

  chk_coef_scale: assert property (
    in_seg[1] && coef_r[1] == 10'(COEF_UNITY) |->
      contrib[1] == CONTRIB_W'($signed(seg_r[1][seg_idx[1]])))
    else $error("Unity coefficient altered the segment.");

  chk_inst_isolate: assert property (
    !run[1] && (start[0] || !exec_two) |=> !run[1])
    else $error("Instance two started without its own command.");

  chk_autotune_load: assert property (
    at_done |=> wait_r[$past(at_sel)] == $past(at_wait) && opt_r[$past(at_sel)] == $past(at_opt) &&
      seg_r[$past(at_sel)] == $past(at_segs))
    else $error("Autotune results not loaded.");

  chk_status_word: assert property (
    rd_pend_r && map_r && addr_r == STATUS2_OFS |=>
      hrdata[2:0] == $past({run[1], run[0], preboost_run_mode_r}))
    else $error("Status word does not match state.");

  chk_abort_stop: assert property (
    abort |=> !run[0] && !run[1])
    else $error("Sequence survived an abort.");

  chk_zero_idle: assert property (
    !in_seg[0] && !in_seg[1] |=> manipulated_output == MV_W'($past(loop_output)))
    else $error("Pre-boost added outside a segment.");

  cov_full_run: cover property (in_seg[0] && seg_idx[0] == 2'h3 ##1 !run[0]);
  cov_inst_two: cover property (in_seg[1]);
  cov_abort_run: cover property (run[0] && abort);
  cov_zero_wait: cover property (start[1] && wait_r[1] == '0 ##1 in_seg[1]);

endmodule

/* testbench/ffps_host.sv */
// Host controller model: an AHB-Lite master that issues register commands.
module ffps_host
  import ffps_pkg::*;
(
  // Clock and slave answer.
  input  wire logic        ref_clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  // Master request.
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero; only whole-word transfers are made.
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // --------------------------------------------------------------
  // One single transfer; the request holds until hready is seen high.
  // --------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
    // A released data bus must not keep showing the old word.
    hwdata <= ~hwdata;
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking testbench for the feedforward pre-boost sequencer.
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module tb
  import ffps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCK = 10;  // Short base tick keeps the run brief.
  logic                     ref_clk, reset_n, hsel, hwrite, hreadyout, at_done, at_sel, hresp;
  logic [31:0]              haddr, hwdata, hrdata, rd;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [4:0]               abort_in;  // Manual, stop, tune, invert, input error.
  logic [WAIT_W-1:0]        at_wait;
  logic [OPT_W-1:0]         at_opt;
  logic [4*SEG_W-1:0]       at_segs;
  logic signed [LOOP_W-1:0] loop_output;
  logic signed [MV_W-1:0]   manipulated_output;
  logic signed [MV_W-1:0]   seen_q[$];  // Each new output value, in order.
  int                       when_q[$], mismatches, tests_run, cyc, t0, seg[4], coef, lo;
  logic [7:0]               ra[6] = '{8'h10, 8'h14, 8'h28, 8'h48, 8'h2c, 8'h04};
  logic [31:0]              rv[6] = '{32'h0, 32'h1, 32'h64, 32'h64, 32'h0, 32'h0};

  ffps_host host (.ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
                  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ffps_sequencer #(.TICK_CYC(TCK)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .manual_cmd(abort_in[0]), .stop_cmd(abort_in[1]), .tune_start(abort_in[2]),
    .invert_cmd(abort_in[3]), .input_error(abort_in[4]), .at_done(at_done), .at_sel(at_sel), .at_wait(at_wait),
    .at_opt(at_opt), .at_segs(at_segs), .loop_output(loop_output), .manipulated_output(manipulated_output));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Expected output: loop value plus the scaled segment, cut toward zero.
  function automatic logic signed [MV_W-1:0] exp_mv(input int base, input int s, input int c);
    return MV_W'(base + (s * c) / 100);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd);
    `CHK($sformatf("reg %0h", a), {1'b0, e}, {hresp, rd})
  endtask
  // Alternating signs keep neighbouring segments distinct and nonzero.
  function automatic int pick_seg(input int k);
    return (k % 2 ? -1 : 1) * int'($urandom_range(1999, 100));
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always #10 ref_clk = ~ref_clk;

  // Logs every change of the output and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (seen_q.size() == 0 || manipulated_output !== seen_q[$]) begin
      seen_q.push_back(manipulated_output);
      when_q.push_back(cyc);
    end
    if (cyc > 30000) begin
      mismatches++;
      finish_test();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; reset_n = 1'b0; abort_in = 5'h0; at_done = 1'b0; at_sel = 1'b0;
    at_wait = '0; at_opt = '0; at_segs = '0; loop_output = '0; mismatches = 0; tests_run = 0; cyc = 0;
    void'($urandom(14821));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) chk_rd(ra[i], rv[i]);
    // Full run of instance one with random values.
    lo = int'($urandom_range(2000)) - 1000;
    loop_output <= LOOP_W'(lo);
    coef = int'($urandom_range(999, 1));
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h1);
    wr(8'h28, 32'(coef));
    for (int k = 0; k < 4; k++) begin
      seg[k] = pick_seg(k);
      wr(8'h18 + 8'(4 * k), 32'(seg[k]));
    end
    chk_rd(8'h1c, 32'(seg[1]));
    seen_q.delete();
    when_q.delete();
    wr(8'h00, 32'h2);
    t0 = cyc;
    chk_rd(8'h04, 32'h2);
    repeat (480) @(posedge ref_clk);
    `CHK("change count", 6, seen_q.size())
    `CHK("wait window", 1'b1, (when_q[1] - t0) inside {[28:44]})
    for (int k = 0; k < 4; k++) begin
      `CHK("segment value", exp_mv(lo, seg[k], coef), seen_q[k + 1])
      `CHK("segment length", 10 * TCK, when_q[k + 2] - when_q[k + 1])
    end
    `CHK("output after run", exp_mv(lo, 0, 1), seen_q[5])
    chk_rd(8'h04, 32'h0);
    // Autotune load into instance two, then each abort cause in turn.
    @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      seg[k] = pick_seg(k);
      at_segs[k * SEG_W +: SEG_W] <= SEG_W'(seg[k]);
    end
    at_sel <= 1'b1; at_wait <= '0; at_opt <= 12'h002; at_done <= 1'b1;
    @(posedge ref_clk);
    at_done <= 1'b0;
    chk_rd(8'h34, 32'h2);
    chk_rd(8'h44, 32'(seg[3]));
    chk_rd(8'h14, 32'h1);
    for (int i = 0; i < 6; i++) begin
      lo = int'($urandom_range(2000)) - 1000;
      loop_output <= LOOP_W'(lo);
      wr(8'h00, 32'h4);
      wr(8'h00, 32'h2);
      chk_rd(8'h04, 32'h4);
      `CHK("output running", exp_mv(lo, seg[0], 100), manipulated_output)
      if (i == 5) begin
        wr(8'h00, 32'h8);
      end else begin
        @(posedge ref_clk);
        abort_in[i] <= 1'b1;
        @(posedge ref_clk);
        abort_in <= 5'h0;
      end
      chk_rd(8'h04, 32'h0);
      `CHK("output aborted", exp_mv(lo, 0, 1), manipulated_output)
    end
    // Autotune mode refuses an execute command.
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h3);
    chk_rd(8'h04, 32'h1);
    // Both execute bits together start instance one only.
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h6);
    chk_rd(8'h04, 32'h2);
    finish_test();
  end
endmodule
